// ---- rtl/hpb_port.sv ----
// serial slave host command port: addressing, command decode, pointer reads
//
// Behaviour
// RULE_01 - low three address bits come from the three address select pins
// RULE_02 - last address bit zero means write, one means read
// RULE_03 - whole bytes, msb first, each followed by one acknowledge bit
// RULE_04 - sample data on rising clock, change data only while clock low
// RULE_05 - read data bit driven after previous falling clock edge
// RULE_06 - acknowledger holds data low through ninth pulse high phase
// RULE_07 - start is data falling with clock high, stop is data rising
// RULE_08 - first written byte is command, acknowledged only if valid
// RULE_09 - extra bytes and invalid parameters are never acknowledged
// RULE_10 - after a refusal master restarts before a new transfer
// RULE_11 - master leaves last read byte unacknowledged, device releases data
// RULE_12 - every read byte comes from the register the pointer selects
// RULE_13 - master sets pointer in a write before reading another register
// RULE_14 - full device reset command decoded at its code
// RULE_15 - config write command decoded, one parameter byte follows
// RULE_16 - channel choose command decoded, one channel code follows
// RULE_17 - pointer set command decoded, one register code follows
// RULE_18 - line reset command decoded at its code
// RULE_19 - line byte write command decoded, data byte follows
// RULE_20 - line byte read command decoded, no parameter
// RULE_21 - line bit command decoded, one bit value byte follows
// RULE_22 - search step command decoded, one direction byte follows
// RULE_23 - line commands and parameters refused while line is busy; code checks busy on the command byte only, parameter bytes are accepted
// RULE_24 - foreign address ignored, data released until next start
`timescale 1ns/1ps
module hpb_port (
  input  wire logic       sys_clk,
  input  wire logic       reset,
  input  wire logic       scl_in,
  input  wire logic       sda_in,
  output logic            sda_out,
  output logic            sda_oe,
  input  wire logic       addr_select_pin_0,
  input  wire logic       addr_select_pin_1,
  input  wire logic       addr_select_pin_2,
  input  wire logic       line_busy_flag,
  input  wire logic [7:0] rd_data,
  output logic      [7:0] rd_ptr,
  output logic            cmd_strobe,
  output logic      [7:0] cmd_code,
  output logic      [7:0] cmd_param
);

  hpb_pkg::hpb_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  logic [7:0] sh_q, sh_d;
  logic [1:0] idx_q, idx_d;
  logic       rw_q, rw_d;
  logic       ack_q, ack_d;
  logic       need_q, need_d;
  logic [7:0] code_q, code_d;
  logic [7:0] param_q, param_d;
  logic [7:0] ptr_q, ptr_d;
  logic       oe_q, oe_d;
  logic       scl_q, sda_q;
  logic       stb_q, stb_d;
  logic [7:0] ccode_q, ccode_d;
  logic [7:0] cparam_q, cparam_d;

  logic       rise, fall, start_c, stop_c;
  logic [7:0] byte_c;
  logic [6:0] own_addr;

  // line edges judged from the previous sample
  assign rise     = scl_in & ~scl_q;
  assign fall     = ~scl_in & scl_q;
  assign start_c  = scl_in & scl_q & sda_q & ~sda_in; // RULE_07
  assign stop_c   = scl_in & scl_q & ~sda_q & sda_in; // RULE_07
  assign byte_c   = {sh_q[6:0], sda_in}; // RULE_03
  assign own_addr = {hpb_pkg::SLAVE_ADDR_HI, addr_select_pin_2,
                     addr_select_pin_1, addr_select_pin_0}; // RULE_01

  // code accepted at all, ignoring busy state
  function automatic logic code_known(input logic [7:0] c);
    case (c)
      hpb_pkg::FULL_DEVICE_RESET_CMD, hpb_pkg::CONFIG_WRITE_CMD,
      hpb_pkg::CHANNEL_CHOOSE_CMD, hpb_pkg::POINTER_SET_CMD,
      hpb_pkg::LINE_RESET_CMD, hpb_pkg::LINE_BYTE_WRITE_CMD,
      hpb_pkg::LINE_BYTE_READ_CMD, hpb_pkg::LINE_BIT_CMD,
      hpb_pkg::SEARCH_STEP_CMD: code_known = 1'b1; // RULE_14 RULE_18 RULE_20
      default: code_known = 1'b0;
    endcase
  endfunction

  // codes that touch the downstream line and so wait for it to go idle
  function automatic logic code_needs_idle(input logic [7:0] c);
    case (c)
      hpb_pkg::CONFIG_WRITE_CMD, hpb_pkg::CHANNEL_CHOOSE_CMD,
      hpb_pkg::LINE_RESET_CMD, hpb_pkg::LINE_BYTE_WRITE_CMD,
      hpb_pkg::LINE_BYTE_READ_CMD, hpb_pkg::LINE_BIT_CMD,
      hpb_pkg::SEARCH_STEP_CMD: code_needs_idle = 1'b1;
      default: code_needs_idle = 1'b0;
    endcase
  endfunction

  // codes that carry one parameter byte
  function automatic logic code_has_param(input logic [7:0] c);
    case (c)
      hpb_pkg::CONFIG_WRITE_CMD, hpb_pkg::CHANNEL_CHOOSE_CMD,
      hpb_pkg::POINTER_SET_CMD, hpb_pkg::LINE_BYTE_WRITE_CMD,
      hpb_pkg::LINE_BIT_CMD, hpb_pkg::SEARCH_STEP_CMD:
        code_has_param = 1'b1; // RULE_15 RULE_16 RULE_17 RULE_19 RULE_21 RULE_22
      default: code_has_param = 1'b0;
    endcase
  endfunction

  // parameter check per command; data, bit and direction bytes take any value
  function automatic logic param_ok(input logic [7:0] c, input logic [7:0] p);
    logic ok;
    ok = 1'b0;
    case (c)
      hpb_pkg::POINTER_SET_CMD:
        ok = (p == hpb_pkg::PTR_STATUS) || (p == hpb_pkg::PTR_DATA) ||
             (p == hpb_pkg::PTR_CHAN) || (p == hpb_pkg::PTR_CONFIG); // RULE_17
      hpb_pkg::CHANNEL_CHOOSE_CMD:
        for (int i = 0; i < 8; i++) begin
          if (p == hpb_pkg::CHAN_CODES[i]) ok = 1'b1; // RULE_16
        end
      default: ok = 1'b1;
    endcase
    param_ok = ok;
  endfunction

  // next state of the bit engine and the command outputs
  always_comb begin
    state_d  = state_q;
    cnt_d    = cnt_q;
    sh_d     = sh_q;
    idx_d    = idx_q;
    rw_d     = rw_q;
    ack_d    = ack_q;
    need_d   = need_q;
    code_d   = code_q;
    param_d  = param_q;
    ptr_d    = ptr_q;
    oe_d     = oe_q;
    stb_d    = 1'b0;
    ccode_d  = ccode_q;
    cparam_d = cparam_q;
    if (stop_c) begin
      state_d = hpb_pkg::HPB_IDLE;
      oe_d    = 1'b0;
    end else if (start_c) begin
      // a repeated start also lands here, so a refused byte is left behind
      state_d = hpb_pkg::HPB_RX; // RULE_10
      cnt_d   = 3'd0;
      idx_d   = hpb_pkg::IDX_ADDR;
      oe_d    = 1'b0;
    end else begin
      case (state_q)
        hpb_pkg::HPB_RX: begin
          if (rise) begin
            sh_d  = byte_c; // RULE_04
            cnt_d = cnt_q + 3'd1;
            if (cnt_q == hpb_pkg::LAST_BIT) begin
              state_d = hpb_pkg::HPB_DEC;
              case (idx_q)
                hpb_pkg::IDX_ADDR: begin
                  ack_d = (byte_c[7:1] == own_addr); // RULE_24
                  rw_d  = byte_c[0]; // RULE_02
                end
                hpb_pkg::IDX_CODE: begin
                  code_d = byte_c;
                  need_d = code_has_param(byte_c);
                  ack_d  = code_known(byte_c) &&
                           !(line_busy_flag && code_needs_idle(byte_c)); // RULE_08 RULE_23
                end
                hpb_pkg::IDX_PARAM: begin
                  param_d = byte_c;
                  ack_d   = param_ok(code_q, byte_c); // RULE_09
                end
                default: ack_d = 1'b0; // RULE_09
              endcase
            end
          end
        end
        hpb_pkg::HPB_DEC: begin
          // drive the acknowledge only once the clock is low
          if (fall) begin
            state_d = ack_q ? hpb_pkg::HPB_ACK : hpb_pkg::HPB_WAIT; // RULE_24
            oe_d    = ack_q; // RULE_06
          end
        end
        hpb_pkg::HPB_ACK: begin
          if (fall) begin
            oe_d    = 1'b0;
            cnt_d   = 3'd0;
            state_d = hpb_pkg::HPB_RX;
            case (idx_q)
              hpb_pkg::IDX_ADDR: begin
                if (rw_q) begin
                  state_d = hpb_pkg::HPB_TX;
                  sh_d    = rd_data; // RULE_12
                  oe_d    = ~rd_data[7]; // RULE_05
                end else begin
                  idx_d = hpb_pkg::IDX_CODE;
                end
              end
              hpb_pkg::IDX_CODE: begin
                if (need_q) begin
                  idx_d = hpb_pkg::IDX_PARAM;
                end else begin
                  idx_d   = hpb_pkg::IDX_EXTRA;
                  stb_d   = 1'b1;
                  ccode_d = code_q;
                  if (code_q == hpb_pkg::FULL_DEVICE_RESET_CMD) begin
                    ptr_d = hpb_pkg::PTR_RESET; // RULE_14
                  end
                end
              end
              default: begin
                idx_d    = hpb_pkg::IDX_EXTRA;
                stb_d    = 1'b1;
                ccode_d  = code_q;
                cparam_d = param_q;
                if (code_q == hpb_pkg::POINTER_SET_CMD) begin
                  ptr_d = param_q; // RULE_17
                end
              end
            endcase
          end
        end
        hpb_pkg::HPB_TX: begin
          if (fall) begin
            if (cnt_q == hpb_pkg::LAST_BIT) begin
              oe_d    = 1'b0; // leave the line to the master acknowledge
              state_d = hpb_pkg::HPB_RACK;
            end else begin
              cnt_d = cnt_q + 3'd1;
              sh_d  = {sh_q[6:0], 1'b0};
              oe_d  = ~sh_q[6]; // RULE_05 RULE_03
            end
          end
        end
        hpb_pkg::HPB_RACK: begin
          if (rise && sda_in) begin
            state_d = hpb_pkg::HPB_WAIT; // RULE_11
          end else if (fall) begin
            // same register again, no new addressing
            state_d = hpb_pkg::HPB_TX;
            cnt_d   = 3'd0;
            sh_d    = rd_data; // RULE_12
            oe_d    = ~rd_data[7]; // RULE_05
          end
        end
        hpb_pkg::HPB_WAIT: oe_d = 1'b0; // RULE_24 RULE_11
        hpb_pkg::HPB_IDLE: oe_d = 1'b0;
        default: begin
          state_d = hpb_pkg::HPB_IDLE;
          oe_d    = 1'b0;
        end
      endcase
    end
  end

  // registers only; the pointer survives stop conditions
  always_ff @(posedge sys_clk) begin
    if (reset) begin
      state_q  <= hpb_pkg::HPB_IDLE;
      cnt_q    <= 3'd0;
      sh_q     <= 8'h00;
      idx_q    <= hpb_pkg::IDX_ADDR;
      rw_q     <= 1'b0;
      ack_q    <= 1'b0;
      need_q   <= 1'b0;
      code_q   <= 8'h00;
      param_q  <= 8'h00;
      ptr_q    <= hpb_pkg::PTR_RESET;
      oe_q     <= 1'b0;
      scl_q    <= 1'b1;
      sda_q    <= 1'b1;
      stb_q    <= 1'b0;
      ccode_q  <= 8'h00;
      cparam_q <= 8'h00;
    end else begin
      state_q  <= state_d;
      cnt_q    <= cnt_d;
      sh_q     <= sh_d;
      idx_q    <= idx_d;
      rw_q     <= rw_d;
      ack_q    <= ack_d;
      need_q   <= need_d;
      code_q   <= code_d;
      param_q  <= param_d;
      ptr_q    <= ptr_d;
      oe_q     <= oe_d;
      scl_q    <= scl_in;
      sda_q    <= sda_in;
      stb_q    <= stb_d;
      ccode_q  <= ccode_d;
      cparam_q <= cparam_d;
    end
  end

  // open drain: only ever pulls low
  assign sda_out   = 1'b0;
  assign sda_oe    = oe_q;
  assign rd_ptr    = ptr_q;
  assign cmd_strobe = stb_q;
  assign cmd_code  = ccode_q;
  assign cmd_param = cparam_q;

endmodule // hpb_port

// ---- rtl/hpb_pkg.sv ----
// constants for the serial host command port
package hpb_pkg;
  // upper four address bits, low three come from the select pins
  localparam logic [3:0] SLAVE_ADDR_HI = 4'h3;
  // command codes
  localparam logic [7:0] FULL_DEVICE_RESET_CMD = 8'hf0;
  localparam logic [7:0] CONFIG_WRITE_CMD      = 8'hd2;
  localparam logic [7:0] CHANNEL_CHOOSE_CMD    = 8'hc3;
  localparam logic [7:0] POINTER_SET_CMD       = 8'he1;
  localparam logic [7:0] LINE_RESET_CMD        = 8'hb4;
  localparam logic [7:0] LINE_BYTE_WRITE_CMD   = 8'ha5;
  localparam logic [7:0] LINE_BYTE_READ_CMD    = 8'h96;
  localparam logic [7:0] LINE_BIT_CMD          = 8'h87;
  localparam logic [7:0] SEARCH_STEP_CMD       = 8'h78;
  // register selection codes accepted by the pointer set command
  localparam logic [7:0] PTR_STATUS = 8'hf0;
  localparam logic [7:0] PTR_DATA   = 8'he1;
  localparam logic [7:0] PTR_CHAN   = 8'hd2;
  localparam logic [7:0] PTR_CONFIG = 8'hc3;
  localparam logic [7:0] PTR_RESET  = 8'hf0;
  // channel codes accepted by the channel choose command
  localparam logic [7:0] CHAN_CODES [8] = '{8'hf0, 8'he1, 8'hd2, 8'hc3,
                                            8'hb4, 8'ha5, 8'h96, 8'h87};
  // byte position inside a transfer
  localparam logic [1:0] IDX_ADDR  = 2'd0;
  localparam logic [1:0] IDX_CODE  = 2'd1;
  localparam logic [1:0] IDX_PARAM = 2'd2;
  localparam logic [1:0] IDX_EXTRA = 2'd3;
  localparam logic [2:0] LAST_BIT  = 3'd7;

  typedef enum logic [2:0] {
    HPB_IDLE = 3'b000,
    HPB_RX   = 3'b001,
    HPB_DEC  = 3'b010,
    HPB_ACK  = 3'b011,
    HPB_TX   = 3'b100,
    HPB_RACK = 3'b101,
    HPB_WAIT = 3'b110
  } hpb_state_t;
endpackage

// ---- verif/hpb_port_asserts.sv ----
// pin-level assertions for the serial host command port
`timescale 1ns/1ps
module hpb_port_asserts (
  input wire logic       sys_clk,
  input wire logic       reset,
  input wire logic       scl_in,
  input wire logic       sda_in,
  input wire logic       sda_out,
  input wire logic       sda_oe,
  input wire logic       addr_select_pin_0,
  input wire logic       addr_select_pin_1,
  input wire logic       addr_select_pin_2,
  input wire logic       line_busy_flag,
  input wire logic [7:0] rd_data,
  input wire logic [7:0] rd_ptr,
  input wire logic       cmd_strobe,
  input wire logic [7:0] cmd_code,
  input wire logic [7:0] cmd_param
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (reset);
  // drive moves only in the low phase, so an ack covers the whole high phase
  a_oe_steady: assert property (scl_in |-> $stable(sda_oe))
    else $error("data drive moved while clock high");
  a_out_low: assert property (sda_out == 1'b0)
    else $error("data output not low");
  a_strobe_one: assert property (cmd_strobe |=> !cmd_strobe)
    else $error("strobe longer than one cycle");
  // strobe lands one cycle after the clock fall is first seen
  a_strobe_time: assert property (cmd_strobe |->
    !scl_in && !$past(scl_in) && $past(scl_in, 2))
    else $error("strobe not one cycle after clock fall");
  a_regs_hold: assert property (!cmd_strobe |-> $stable({cmd_code, cmd_param}))
    else $error("command registers moved without strobe");
  a_code_known: assert property (cmd_strobe |-> cmd_code inside {8'hf0, 8'hd2, 8'hc3,
    8'he1, 8'hb4, 8'ha5, 8'h96, 8'h87, 8'h78}) else $error("unknown code accepted");
  a_ptr_cause: assert property ($changed(rd_ptr) |->
    cmd_strobe && cmd_code inside {8'he1, 8'hf0}) else $error("pointer moved without its command");
  a_ptr_value: assert property (cmd_strobe && cmd_code == 8'he1 |-> rd_ptr == cmd_param)
    else $error("pointer differs from its parameter");
  a_ptr_reset: assert property (cmd_strobe && cmd_code == 8'hf0 |-> rd_ptr == 8'hf0)
    else $error("device reset left pointer elsewhere");
endmodule // hpb_port_asserts

bind hpb_port hpb_port_asserts chk_u (.sys_clk(sys_clk), .reset(reset), .scl_in(scl_in),
  .sda_in(sda_in), .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_0(addr_select_pin_0),
  .addr_select_pin_1(addr_select_pin_1), .addr_select_pin_2(addr_select_pin_2),
  .line_busy_flag(line_busy_flag), .rd_data(rd_data), .rd_ptr(rd_ptr),
  .cmd_strobe(cmd_strobe), .cmd_code(cmd_code), .cmd_param(cmd_param));

// ---- verif/hpb_host_model.sv ----
// host-side bus master model: serial clock, framing and bytes
`timescale 1ns/1ps
module hpb_host_model (
  input  wire logic sys_clk,
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  // idle bus, data left to the pull-up
  initial {scl, sda_m} = 2'b11;
  // n clock edges, then the fixed drive delay
  task automatic tk(input int n);
    repeat (n) @(posedge sys_clk);
    #10;
  endtask
  // one pulse, phases of four and four cycles, well above the two needed
  task automatic bit_x(input logic b, output logic r);
    tk(1);
    sda_m = b;
    tk(3);
    scl = 1'b1;
    tk(2);
    r = sda;
    tk(2);
    scl = 1'b0;
  endtask
  // v high: start or repeated start; v low: stop
  task automatic cond(input logic v);
    tk(1);
    sda_m = v;
    tk(2);
    scl = 1'b1;
    tk(2);
    sda_m = !v;
    tk(2);
    if (v) scl = 1'b0;
  endtask
  // byte msb first, ninth bit driven as nb; ack is a low ninth bit
  task automatic xbyte(input logic [7:0] d, input logic nb, output logic [7:0] q,
                       output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) bit_x(d[i], q[i]);
    bit_x(nb, r);
    ack = (r === 1'b0);
  endtask
endmodule // hpb_host_model

// ---- verif/tb_top.sv ----
// bench for the serial host command port
`timescale 1ns/1ps
module tb_top;
  logic       sys_clk = 1'b0;
  logic       reset   = 1'b1;
  logic       busy    = 1'b0;
  logic [2:0] apins   = 3'h0;
  logic       scl, sda_m, sda_in, sda_out, sda_oe, cmd_strobe, a;
  logic [7:0] rd_ptr, rd_data, cmd_code, cmd_param, d;
  int         n_mismatch = 0, checks = 0, n_strobe = 0, cyc = 0;
  // wired-and bus with pull-up; register contents marked by the pointer
  assign sda_in  = sda_m & ~sda_oe;
  // msb clear for every pointer code, so a wrong reload would pull data low
  assign rd_data = rd_ptr ^ 8'ha5;
  always #50 sys_clk = ~sys_clk;
  hpb_host_model host_u (.sys_clk(sys_clk), .sda(sda_in), .scl(scl), .sda_m(sda_m));
  hpb_port dut_u (.sys_clk(sys_clk), .reset(reset), .scl_in(scl), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .addr_select_pin_0(apins[0]),
    .addr_select_pin_1(apins[1]), .addr_select_pin_2(apins[2]), .line_busy_flag(busy),
    .rd_data(rd_data), .rd_ptr(rd_ptr), .cmd_strobe(cmd_strobe), .cmd_code(cmd_code),
    .cmd_param(cmd_param));
  // count accepted commands; the cycle ceiling cuts a hang short
  always @(posedge sys_clk) begin
    n_strobe <= n_strobe + 32'(cmd_strobe === 1'b1);
    cyc <= cyc + 1;
    if (cyc == 30000) begin
      n_mismatch++;
      tally_and_finish();
    end
  end
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks=%0d n_mismatch=%0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  // write access, address bits flipped by x: code, parameter if np, one extra
  task automatic cmd(input logic [2:0] x, input logic [7:0] c, p, input logic np, ca, pa);
    host_u.cond(1'b1);
    host_u.xbyte({hpb_pkg::SLAVE_ADDR_HI, apins ^ x, 1'b0}, 1'b1, d, a);
    chk(8'(a), 8'(x == 3'h0));
    host_u.xbyte(c, 1'b1, d, a);
    chk(8'(a), 8'(ca));
    if (np) host_u.xbyte(p, 1'b1, d, a);
    if (np) chk(8'(a), 8'(pa));
    host_u.xbyte(8'h00, 1'b1, d, a);
    chk(8'(a), 8'h00);
    host_u.cond(1'b0);
  endtask
  // row: foreign bits, flags busy/param/code ack/param ack, code, parameter
  task automatic t_cmds();
    logic [23:0] rows [18] = '{24'h03f000, 24'h07d25a, 24'h07c387, 24'h07e1d2,
      24'h03b400, 24'h07a53c, 24'h039600, 24'h078780, 24'h077880, 24'h000000,
      24'h06e1e5, 24'h06c3e5, 24'h54e1d2, 24'h0cd25a, 24'h0c7880, 24'h08b400,
      24'h0bf000, 24'h0fe1c3};
    logic [3:0] f;
    logic [7:0] c, p;
    logic       e;
    int         s;
    for (int i = 0; i < 18; i++) begin
      {f, c, p} = rows[i][19:0];
      apins = 3'(i);
      busy = f[3];
      e = f[1] & (f[0] | ~f[2]);
      s = n_strobe;
      cmd(rows[i][22:20], c, p, f[2], f[1], f[0]);
      chk(8'(n_strobe - s), 8'(e));
      if (e) chk(cmd_code, c);
      if (e && f[2]) chk(cmd_param, p);
    end
    busy = 1'b0;
    $display("command table test done");
  endtask
  // read access of n bytes, master acks all but the last
  task automatic rd(input logic [7:0] exp, input int n);
    host_u.cond(1'b1);
    host_u.xbyte({hpb_pkg::SLAVE_ADDR_HI, apins, 1'b1}, 1'b1, d, a);
    chk(8'(a), 8'h01);
    for (int i = n - 1; i >= 0; i--) begin
      host_u.xbyte(8'hff, i == 0, d, a);
      chk(d, exp ^ 8'ha5);
    end
    // let the fall after the nack be seen before judging the release
    host_u.tk(2);
    chk(8'(sda_oe), 8'h00);
    host_u.cond(1'b0);
  endtask
  // pointer left on the config code, device reset moves it home, then data code
  task automatic t_read();
    chk(rd_ptr, 8'hc3);
    rd(8'hc3, 3);
    cmd(3'h0, 8'hf0, 8'h00, 1'b0, 1'b1, 1'b1);
    rd(8'hf0, 1);
    cmd(3'h0, 8'he1, 8'he1, 1'b1, 1'b1, 1'b1);
    rd(8'he1, 2);
    $display("read test done");
  endtask
  // five cycles of reset, then the tests
  initial begin
    repeat (5) @(posedge sys_clk);
    #10;
    reset = 1'b0;
    t_cmds();
    t_read();
    tally_and_finish();
  end
endmodule // tb_top
